//--- hw/chan_b_ctrl.sv
/*
 * Second output channel control: register set, integer divider with
 * alignment delay and clean switching, and the output driver stage.
 * Assumes prescaler and reference clocks arrive as pins far slower than
 * clock, and that the neighbouring channel dividers are on clock.
 */
`timescale 1ns/1ps
module chan_b_ctrl
	import chan_b_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire reg_req_t reg_req,
	output logic [REG_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic prescaler_a,
	input wire logic prescaler_b,
	input wire logic reference,
	input wire logic align_pin,
	input wire logic first_channel_divider,
	input wire logic third_channel_divider,
	output logic second_channel_divider,
	output logic out_p,
	output logic out_n,
	output logic out_p_en,
	output logic out_n_en,
	output logic [2:0] driver_format,
	output logic low_supply_flag,
	output logic divider_powered_down
);
	logic [1:0] rst_pipe_r;
	logic rst_n;
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_s;
	logic [REG_W-1:0] regs_r [NUM_REGS];
	logic [NUM_REGS:0] reg_hit;
	logic [REG_W-1:0] reg_rdata_r;
	logic reg_rvalid_r;
	logic align_prev_r;
	logic align_pulse;
	src_sel_t cfg_src;
	logic [DIV_W-1:0] cfg_div;
	logic [DLY_W-1:0] cfg_delay;
	logic cfg_align_en;
	logic cfg_clean;
	src_sel_t act_src_r;
	logic [DIV_W-1:0] act_div_r;
	div_state_t state_r;
	logic [DIV_W-1:0] cnt_r;
	logic [DLY_W-1:0] wait_r;
	logic src_prev_r;
	logic sel_lvl;
	logic src_edge;
	logic wrap;
	logic cfg_pending;
	logic apply_now;
	logic [DIV_W:0] high_len;
	logic div_clk_r;
	logic routed;
	driver_format_t fmt;
	out_sel_t osel;
	logic [1:0] pol;
	logic silence;
	logic silence_lvl;
	pin_drive_t drive_nxt;
	pin_drive_t drive_r;

	// Address decode used by both the write and the read path.
	function automatic logic [NUM_REGS:0] decode(input logic [ADDR_W-1:0] addr);
		logic [NUM_REGS:0] hit;
		hit = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (addr == REG_OFFSETS[i]) begin
				hit[i] = 1'b1;
			end
		end
		hit[NUM_REGS] = |hit[NUM_REGS-1:0];
		return hit;
	endfunction

	function automatic logic pick_source(input src_sel_t s, input logic [2:0] lvl);
		case (s)
			SRC_PRESCALER_A: pick_source = lvl[0];
			SRC_PRESCALER_B: pick_source = lvl[1];
			SRC_REFERENCE: pick_source = lvl[2];
			default: pick_source = 1'b0;
		endcase
	endfunction

	function automatic logic is_single_ended(input driver_format_t f);
		return (f == FMT_SINGLE_ENDED_BOTH_PINS) || (f == FMT_SINGLE_ENDED_POSITIVE_PIN) ||
			(f == FMT_SINGLE_ENDED_NEGATIVE_PIN);
	endfunction

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_pipe_r <= 2'b00;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	assign pin_raw = {align_pin, reference, prescaler_b, prescaler_a};

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_sync
			sync_2ff u_sync (
				.clock(clock),
				.rst_n(rst_n),
				.async_in(pin_raw[g]),
				.sync_out(pin_s[g])
			);
		end
	endgenerate

	assign reg_hit = decode(reg_req.addr);

	// All fields, reserved ones included, are stored as written and read back.
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_reg
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					regs_r[g] <= REG_RESETS[g];
				end else if (reg_req.wr && reg_hit[g]) begin
					regs_r[g] <= reg_req.wdata;
				end
			end
		end
	endgenerate

	// Unmapped reads answer zero; a read in the same cycle as a write sees the old value.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= '0;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_req.rd;
			if (reg_req.rd) begin
				if (!reg_hit[NUM_REGS]) begin
					reg_rdata_r <= '0;
				end
				for (int i = 0; i < NUM_REGS; i++) begin
					if (reg_hit[i]) begin
						reg_rdata_r <= regs_r[i];
					end
				end
			end
		end
	end

	assign cfg_src = src_sel_t'(regs_r[IDX_DIVIDER][SRC_LSB +: 2]);
	assign cfg_div = regs_r[IDX_DIVIDER][DIV_LSB +: DIV_W];
	assign cfg_delay = regs_r[IDX_OUTPUT][DLY_LSB +: DLY_W];
	assign cfg_align_en = regs_r[IDX_OUTPUT][ALIGN_EN_BIT];
	assign silence_lvl = regs_r[IDX_OUTPUT][SILENCE_LVL_BIT];
	assign silence = regs_r[IDX_OUTPUT][SILENCE_BIT];
	assign pol = regs_r[IDX_OUTPUT][POL_LSB +: 2];
	assign fmt = driver_format_t'(regs_r[IDX_OUTPUT][FMT_LSB +: 3]);
	assign osel = out_sel_t'(regs_r[IDX_OUTPUT][OSEL_LSB +: 2]);
	assign cfg_clean = regs_r[IDX_SWITCHING][CLEAN_BIT];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			align_prev_r <= 1'b0;
		end else begin
			align_prev_r <= pin_s[3];
		end
	end
	assign align_pulse = pin_s[3] & ~align_prev_r;

	assign sel_lvl = pick_source(act_src_r, pin_s[2:0]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_prev_r <= 1'b0;
		end else begin
			src_prev_r <= sel_lvl;
		end
	end
	assign src_edge = sel_lvl & ~src_prev_r;

	assign wrap = src_edge && (state_r == ST_RUN) &&
		(cnt_r == act_div_r - {{(DIV_W-1){1'b0}}, 1'b1});
	assign cfg_pending = (cfg_src != act_src_r) || (cfg_div != act_div_r);
	// Clean mode holds a new setting back until the running period ends.
	assign apply_now = cfg_pending && (!cfg_clean || (state_r != ST_RUN) || wrap);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act_src_r <= SRC_PRESCALER_A;
			act_div_r <= '0;
		end else if (apply_now) begin
			act_src_r <= cfg_src;
			act_div_r <= cfg_div;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_OFF;
			cnt_r <= '0;
			wait_r <= '0;
		end else if (act_div_r == '0) begin
			state_r <= ST_OFF;
			cnt_r <= '0;
			wait_r <= '0;
		end else begin
			case (state_r)
				ST_OFF: begin
					state_r <= ST_RUN;
					cnt_r <= '0;
				end
				ST_RUN: begin
					if (align_pulse && cfg_align_en) begin
						state_r <= ST_ALIGN_WAIT;
						wait_r <= '0;
					end else if (apply_now && !wrap) begin
						cnt_r <= '0;
					end else if (wrap) begin
						cnt_r <= '0;
					end else if (src_edge) begin
						cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
					end
				end
				ST_ALIGN_WAIT: begin
					if (align_pulse && cfg_align_en) begin
						wait_r <= '0;
					end else if (src_edge) begin
						if (wait_r == cfg_delay) begin
							state_r <= ST_RUN;
							cnt_r <= '0;
						end else begin
							wait_r <= wait_r + {{(DLY_W-1){1'b0}}, 1'b1};
						end
					end
				end
				default: begin
					state_r <= ST_OFF;
				end
			endcase
		end
	end

	// Odd ratios get the longer half high; ratio one passes the input through.
	assign high_len = ({1'b0, act_div_r} + {{DIV_W{1'b0}}, 1'b1}) >> 1;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_clk_r <= 1'b0;
		end else if (state_r != ST_RUN) begin
			div_clk_r <= 1'b0;
		end else if (act_div_r == {{(DIV_W-1){1'b0}}, 1'b1}) begin
			div_clk_r <= sel_lvl;
		end else begin
			div_clk_r <= ({1'b0, cnt_r} < high_len);
		end
	end

	always_comb begin
		case (osel)
			OSEL_FIRST_CHANNEL_DIVIDER: routed = first_channel_divider;
			OSEL_SECOND_CHANNEL_DIVIDER: routed = div_clk_r;
			OSEL_THIRD_CHANNEL_DIVIDER: routed = third_channel_divider;
			default: routed = 1'b0;
		endcase
	end

	always_comb begin
		drive_nxt.p_en = 1'b1;
		drive_nxt.n_en = 1'b1;
		if (silence) begin
			drive_nxt.p = silence_lvl;
			drive_nxt.n = ~silence_lvl;
		end else if (is_single_ended(fmt)) begin
			drive_nxt.p = routed ^ pol[1];
			drive_nxt.n = routed ^ pol[0];
		end else begin
			drive_nxt.p = routed;
			drive_nxt.n = ~routed;
		end
		case (fmt)
			FMT_OFF: begin
				drive_nxt = '0;
			end
			FMT_SINGLE_ENDED_POSITIVE_PIN: begin
				drive_nxt.n = 1'b0;
				drive_nxt.n_en = 1'b0;
			end
			FMT_SINGLE_ENDED_NEGATIVE_PIN: begin
				drive_nxt.p = 1'b0;
				drive_nxt.p_en = 1'b0;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive_r <= '0;
		end else begin
			drive_r <= drive_nxt;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign reg_rvalid = reg_rvalid_r;
	assign second_channel_divider = div_clk_r;
	assign out_p = drive_r.p;
	assign out_n = drive_r.n;
	assign out_p_en = drive_r.p_en;
	assign out_n_en = drive_r.n_en;
	assign driver_format = regs_r[IDX_OUTPUT][FMT_LSB +: 3];
	// The supply flag is only passed on; software must match it to the rail.
	assign low_supply_flag = regs_r[IDX_SUPPLY][LOW_SUPPLY_BIT];
	assign divider_powered_down = (state_r == ST_OFF);
endmodule

//--- hw/chan_b_pkg.sv
/*
 * Shared constants and types for the second output channel control block:
 * register offsets, reset values, field positions, mode codes and carriers.
 * Assumes 16-bit registers reached through a simple internal register port.
 */
package chan_b_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 8;
	localparam int NUM_REGS = 6;
	localparam int DIV_W = 14;
	localparam int DLY_W = 5;
	localparam int NUM_PINS = 4;

	localparam logic [ADDR_W-1:0] OFS_RESERVED0 = 8'h29;
	localparam logic [ADDR_W-1:0] OFS_RESERVED1 = 8'h2a;
	localparam logic [ADDR_W-1:0] OFS_DIVIDER = 8'h2b;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_SWITCHING = 8'h2d;
	localparam logic [ADDR_W-1:0] OFS_SUPPLY = 8'h2e;

	localparam int IDX_RESERVED0 = 0;
	localparam int IDX_RESERVED1 = 1;
	localparam int IDX_DIVIDER = 2;
	localparam int IDX_OUTPUT = 3;
	localparam int IDX_SWITCHING = 4;
	localparam int IDX_SUPPLY = 5;

	localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFFSETS = {
		OFS_SUPPLY, OFS_SWITCHING, OFS_OUTPUT, OFS_DIVIDER, OFS_RESERVED1, OFS_RESERVED0
	};
	localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_RESETS = {
		16'h0008, 16'h0071, 16'h0008, 16'h0000, 16'h0000, 16'h8000
	};

	localparam int SRC_LSB = 14;
	localparam int DIV_LSB = 0;
	localparam int DLY_LSB = 11;
	localparam int ALIGN_EN_BIT = 10;
	localparam int SILENCE_LVL_BIT = 8;
	localparam int SILENCE_BIT = 7;
	localparam int POL_LSB = 5;
	localparam int FMT_LSB = 2;
	localparam int OSEL_LSB = 0;
	localparam int CLEAN_BIT = 0;
	localparam int LOW_SUPPLY_BIT = 3;

	typedef enum logic [1:0] {
		SRC_PRESCALER_A = 2'h0,
		SRC_PRESCALER_B = 2'h1,
		SRC_UNUSED = 2'h2,
		SRC_REFERENCE = 2'h3
	} src_sel_t;

	typedef enum logic [2:0] {
		FMT_OFF = 3'h0,
		FMT_LVDS = 3'h1,
		FMT_HCSL = 3'h2,
		FMT_CML = 3'h3,
		FMT_LVPECL = 3'h4,
		FMT_SINGLE_ENDED_BOTH_PINS = 3'h5,
		FMT_SINGLE_ENDED_POSITIVE_PIN = 3'h6,
		FMT_SINGLE_ENDED_NEGATIVE_PIN = 3'h7
	} driver_format_t;

	typedef enum logic [1:0] {
		OSEL_FIRST_CHANNEL_DIVIDER = 2'h0,
		OSEL_SECOND_CHANNEL_DIVIDER = 2'h1,
		OSEL_THIRD_CHANNEL_DIVIDER = 2'h2,
		OSEL_NONE = 2'h3
	} out_sel_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_ALIGN_WAIT = 2'b11
	} div_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic p;
		logic n;
		logic p_en;
		logic n_en;
	} pin_drive_t;
endpackage

//--- hw/sync_2ff.sv
/*
 * Two flip-flop level synchroniser for one asynchronous input.
 * Assumes the reset given is already synchronous to clock.
 */
`timescale 1ns/1ps
module sync_2ff (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r;

	// The first stage feeds only the second, so no logic sees a metastable value.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

//--- verification/chan_b_ctrl_sva.sv
/* Port checker for the channel control block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module chan_b_ctrl_chk
	import chan_b_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire reg_req_t reg_req,
	input wire logic reg_rvalid,
	input wire logic second_channel_divider,
	input wire logic out_p,
	input wire logic out_n,
	input wire logic out_p_en,
	input wire logic out_n_en,
	input wire logic [2:0] driver_format,
	input wire logic low_supply_flag,
	input wire logic divider_powered_down
);
	logic [2:0] live_r;

	// The block's own reset lags nrst by two edges, so checking waits for it.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			live_r <= 3'h0;
		end else begin
			live_r <= {live_r[1:0], 1'b1};
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!live_r[2]);

	chk_read_answered: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read not answered");
	chk_no_stray_rvalid: assert property (!reg_req.rd |=> !reg_rvalid)
		else $error("rvalid without read");
	chk_format_off_quiet: assert property (driver_format == 3'h0
		|=> !(out_p || out_n || out_p_en || out_n_en))
		else $error("pins active while off");
	chk_pos_pin_only: assert property (driver_format == 3'h6
		|=> out_p_en && !out_n_en && !out_n)
		else $error("negative pin used");
	chk_neg_pin_only: assert property (driver_format == 3'h7
		|=> out_n_en && !out_p_en && !out_p)
		else $error("positive pin used");
	chk_diff_pair: assert property (driver_format inside {[3'h1:3'h4]}
		|=> out_p_en && out_n_en && (out_p != out_n))
		else $error("pair not complementary");
	chk_off_stays_low: assert property (divider_powered_down ##1
		divider_powered_down |-> !second_channel_divider)
		else $error("divider output while off");
	chk_div_wakes: assert property (reg_req.wr && reg_req.addr == OFS_DIVIDER
		&& reg_req.wdata[13:0] != 14'h0 |-> ##[1:4] !divider_powered_down)
		else $error("divider did not start");
	chk_supply_write: assert property (reg_req.wr && reg_req.addr == OFS_SUPPLY
		|=> low_supply_flag == $past(reg_req.wdata[LOW_SUPPLY_BIT]))
		else $error("supply flag not updated");
	chk_format_write: assert property (reg_req.wr && reg_req.addr == OFS_OUTPUT
		|=> driver_format == $past(reg_req.wdata[4:2]))
		else $error("format not updated");
endmodule

bind chan_b_ctrl chan_b_ctrl_chk chk_i (.clock(clock), .nrst(nrst), .reg_req(reg_req),
	.reg_rvalid(reg_rvalid), .second_channel_divider(second_channel_divider),
	.out_p(out_p), .out_n(out_n), .out_p_en(out_p_en), .out_n_en(out_n_en),
	.driver_format(driver_format), .low_supply_flag(low_supply_flag),
	.divider_powered_down(divider_powered_down));

//--- verification/tb_chan_b_ctrl.sv
/* Self-checking bench for the channel control block.
   Assumes the checker is bound in; prescaler and reference pins run free. */
`timescale 1ns/1ps
module tb_chan_b_ctrl;
	import chan_b_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	reg_req_t reg_req = '0;
	logic prescaler_a = 1'b0;
	logic prescaler_b = 1'b0;
	logic reference = 1'b0;
	logic align_pin = 1'b0;
	logic first_div = 1'b0;
	logic third_div = 1'b0;
	logic [REG_W-1:0] reg_rdata;
	logic reg_rvalid, second_channel_divider, out_p, out_n, out_p_en, out_n_en;
	logic [2:0] driver_format;
	logic low_supply_flag, divider_powered_down;
	int miscompares = 0;
	int checks_done = 0;
	int rises = 0;

	chan_b_ctrl dut (.clock(clock), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .prescaler_a(prescaler_a), .prescaler_b(prescaler_b),
		.reference(reference), .align_pin(align_pin), .first_channel_divider(first_div),
		.third_channel_divider(third_div), .second_channel_divider(second_channel_divider),
		.out_p(out_p), .out_n(out_n), .out_p_en(out_p_en), .out_n_en(out_n_en),
		.driver_format(driver_format), .low_supply_flag(low_supply_flag),
		.divider_powered_down(divider_powered_down));

	initial forever #5 clock = ~clock;
	// Half periods land on falling clock edges, away from the sampling edge.
	always #80 prescaler_a = ~prescaler_a;
	always #120 prescaler_b = ~prescaler_b;
	always #160 reference = ~reference;
	always @(posedge second_channel_divider) rises++;

	task automatic test_done();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clock);
		reg_req = {1'b1, 1'b0, a, v};
		@(negedge clock);
		reg_req = '0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [15:0] x);
		int n;
		@(negedge clock);
		reg_req = {1'b0, 1'b1, a, 16'h0};
		@(negedge clock);
		reg_req = '0;
		for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
			@(negedge clock);
		end
		if (n == 4) begin
			miscompares++;
			test_done();
		end
		chk($sformatf("reg %h", a), reg_rdata, x);
	endtask

	task automatic meas(input int cyc, input int x);
		rises = 0;
		repeat (cyc) @(negedge clock);
		chk("rises", 16'(rises), 16'(x));
	endtask

	initial begin
		int i;
		int h[3] = '{8, 12, 16};
		logic [1:0] s[3] = '{2'h0, 2'h1, 2'h3};
		repeat (12) @(negedge clock);
		nrst = 1'b1;
		repeat (4) @(negedge clock);
		chk("format", 16'(driver_format), 16'h2);
		chk("supply", 16'(low_supply_flag), 16'h1);
		for (i = 0; i < NUM_REGS; i++) begin
			rc(REG_OFFSETS[i], REG_RESETS[i]);
			wr(REG_OFFSETS[i], ~REG_RESETS[i]);
			rc(REG_OFFSETS[i], ~REG_RESETS[i]);
			wr(REG_OFFSETS[i], REG_RESETS[i]);
		end
		wr(8'h28, 16'hffff);
		rc(8'h28, 16'h0);
		$display("test registers done");
		wr(OFS_SWITCHING, 16'h0070);
		wr(OFS_OUTPUT, 16'h0009);
		for (i = 0; i < 3; i++) begin
			wr(OFS_DIVIDER, {s[i], 14'h4});
			repeat (100) @(negedge clock);
			meas(32 * h[i], 4);
		end
		wr(OFS_DIVIDER, 16'h0);
		repeat (8) @(negedge clock);
		chk("off", 16'(divider_powered_down), 16'h1);
		meas(256, 0);
		$display("test divider done");
		wr(OFS_DIVIDER, 16'h0004);
		repeat (100) @(negedge clock);
		for (i = 0; i < 2; i++) begin
			wr(OFS_OUTPUT, {5'h1f, i[0], 10'h009});
			align_pin = 1'b1;
			repeat (4) @(negedge clock);
			align_pin = 1'b0;
			repeat (8) @(negedge clock);
			meas(256, i ? 0 : 4);
			repeat (600) @(negedge clock);
		end
		$display("test alignment done");
		wr(OFS_SWITCHING, 16'h0071);
		rises = 0;
		for (i = 0; i < 100 && rises == 0; i++) begin
			@(negedge clock);
		end
		if (rises == 0) begin
			miscompares++;
			test_done();
		end
		// A period has just begun, so the next boundary is a full period away.
		wr(OFS_DIVIDER, 16'h0);
		repeat (8) @(negedge clock);
		chk("clean hold", 16'(divider_powered_down), 16'h0);
		repeat (80) @(negedge clock);
		chk("clean apply", 16'(divider_powered_down), 16'h1);
		$display("test clean switch done");
		wr(OFS_DIVIDER, 16'h0);
		first_div = 1'b1;
		for (i = 0; i < 8; i++) begin
			wr(OFS_OUTPUT, {9'h0, i[1:0], 3'h5, i[2], 1'b0});
			repeat (3) @(negedge clock);
			chk("pins", {out_p, out_n}, {~i[2] ^ i[1], ~i[2] ^ i[0]});
		end
		third_div = 1'b1;
		wr(OFS_OUTPUT, 16'h0015);
		repeat (3) @(negedge clock);
		chk("own div", {out_p, out_n}, 16'h0);
		for (i = 0; i < 2; i++) begin
			wr(OFS_OUTPUT, {7'h0, i[0], 1'b1, 2'h3, 3'h5, 2'h0});
			repeat (3) @(negedge clock);
			chk("mute", {out_p, out_n}, {i[0], ~i[0]});
		end
		wr(OFS_OUTPUT, 16'h0014);
		repeat (3) @(negedge clock);
		chk("unmute", {out_p, out_n}, 16'h3);
		for (i = 0; i < 8; i++) begin
			wr(OFS_OUTPUT, {11'h0, i[2:0], 2'h0});
			repeat (3) @(negedge clock);
			chk("en", {out_p_en, out_n_en}, 16'(i == 0 ? 0 : i == 6 ? 2 : i == 7 ? 1 : 3));
		end
		$display("test output stage done");
		test_done();
	end
endmodule
